/* File: hdl/pco_backup_mem.v */
// Purpose: small state store that keeps counter values across power loss
// Assumes: one write and one read port, one clock
// Notes: read data is registered, one cycle of latency
`timescale 1ns/1ps
module pco_backup_mem #(
  parameter DEPTH = 4,
  parameter AW = 2,
  parameter W = 32
) (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Write port
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [W-1:0] wdata,
  // Read port
  input wire [AW-1:0] raddr,
  output reg [W-1:0] rdata
);
  reg [W-1:0] mem [0:DEPTH-1];

  // Storage write
  always @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= {W{1'b0}};
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // pco_backup_mem

/* File: hdl/pco_counter.v */
// Purpose: output, backup and indicator logic of a six-digit preset counter
// Assumes: count and reset inputs synchronous to clock, one count per edge
// Notes: registers on Avalon-MM, one wait state per access
//
// Behaviour
// - Accumulated output ON counts are read-only monitor values.
// - One monitor unit equals 1,000 output ON events.
// - Allocation off: first to relay, second to three-terminal; on swaps.
// - Each output has own inversion; closed mode turns off at set value.
// - Backup on restores value and outputs after power loss; off resets.
// - Wrap on: decrementing past zero loads 999999 and keeps counting.
// - Wrap off: below zero follows output mode, no wrap to top.
// - Wrap setting only applies in 1-stage, 2-stage, forecast and total modes.
// - Ratio mode drives six segments from present value over set value.
// - Forced-dark mode keeps every segment off.
// - Forced-lit mode keeps every segment on.
// - Incrementing lights segments from left at each sixth, all at full.
// - Rollover from top to zero blanks segments until counting resumes.
// - Decrementing turns segments off from right, all off at one sixth.
// - Wrap from zero to top lights every segment.
// - Operating time is a read-only monitor in 0.1 year steps.
// - Preset modes drive outputs when value reaches set value one or two.
// - Forecast set value is a deviation below the main set value.
// - Batch mode counts completions, first output on at batch set value.
// - Dual value is A plus B, or A minus B in subtract mode.
// - Dual mode drives outputs when dual value reaches its set value.
// - Twin mode keeps two values with two separate set values.
// - Configuration applies on return to run, set values at once; a change clears value and outputs.
//
// Register access over Avalon-MM and the register offsets were decided locally.
`timescale 1ns/1ps
`include "pco_regs.vh"
module pco_counter #(
  parameter [63:0] CLK_HZ = `PCO_CLK_HZ,
  parameter [63:0] RT_STEP_CYCLES = `PCO_RT_STEP_S * CLK_HZ
) (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Avalon-MM slave
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire [3:0] byteenable,
  input wire [31:0] writedata,
  output wire waitrequest,
  output reg [31:0] readdata,
  // Field inputs
  input wire count_input_a,
  input wire count_input_b,
  input wire count_down,
  input wire reset_input_1,
  input wire reset_input_2,
  input wire power_ok,
  // Field outputs
  output reg relay_group_out,
  output reg three_term_group_out,
  output reg [5:0] status_segments
);
  localparam ST_RUN = 2'b00;
  localparam ST_OFF = 2'b01;
  localparam ST_LOAD = 2'b10;

  reg [1:0] state;
  reg ack;
  reg [`PCO_CF_W-1:0] cfg_sw;
  reg [`PCO_CF_W-1:0] cfg;
  reg run_sw;
  reg run_q;
  reg signed [20:0] sv1;
  reg signed [20:0] sv2;
  reg signed [20:0] bsv;
  reg signed [20:0] pv_a;
  reg signed [20:0] pv_b;
  reg signed [20:0] tot;
  reg signed [20:0] bat;
  reg o1;
  reg o2;
  reg [1:0] ind_force;
  reg prev_a;
  reg prev_b;
  reg [2:0] ld_idx;
  reg [1:0] wr_idx;
  reg [31:0] wr_data;
  reg [9:0] on_sub1;
  reg [9:0] on_sub2;
  reg [31:0] on_mon1;
  reg [31:0] on_mon2;
  reg on_q1;
  reg on_q2;
  reg [63:0] rt_cnt;
  reg [31:0] rt_mon;
  wire [31:0] bk_rdata;

  // Shared arithmetic
  function [22:0] step;
    input signed [20:0] v;
    input dn;
    input wrap;
    begin
      step = {2'b00, v + 21'sd1};
      if (!dn && v == `PCO_PV_TOP) begin
        step = {2'b10, `PCO_PV_ZERO};
      end else if (dn && wrap && v == `PCO_PV_ZERO) begin
        step = {2'b01, `PCO_PV_TOP};
      end else if (dn && v == `PCO_PV_LOW) begin
        step = {2'b00, v};
      end else if (dn) begin
        step = {2'b00, v - 21'sd1};
      end
    end
  endfunction

  function [2:0] lit_count;
    input signed [21:0] pv;
    input signed [21:0] sv;
    input dn;
    integer k;
    reg signed [25:0] p6;
    reg signed [25:0] ks;
    begin
      lit_count = 3'd0;
      p6 = ({{4{pv[21]}}, pv} <<< 2) + ({{4{pv[21]}}, pv} <<< 1);
      ks = 26'sd0;
      for (k = 1; k <= 6; k = k + 1) begin
        ks = ks + {{4{sv[21]}}, sv};
        if (dn ? (p6 > ks) : (p6 >= ks)) begin
          lit_count = lit_count + 3'd1;
        end
      end
      if (sv <= 22'sd0) begin
        lit_count = 3'd6;
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    integer i;
    begin
      merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          merge[i*8 +: 8] = nw[i*8 +: 8];
        end
      end
    end
  endfunction

  // Bus handshake: one wait state, then answer
  assign waitrequest = (read | write) & ~ack;

  wire wr_go = write & ack;
  wire [2:0] mode = cfg[`PCO_CF_MODE];
  wire wrap_eff = cfg[`PCO_CF_WRAP] & (mode <= `PCO_M_TOTAL);
  wire dn_a = count_down & (mode <= `PCO_M_BATCH);
  wire ev_a = count_input_a & ~prev_a & ~reset_input_1;
  wire ev_b = count_input_b & ~prev_b & ~reset_input_2;
  wire [22:0] sa = step(pv_a, dn_a, wrap_eff);
  wire [22:0] sb = step(pv_b, 1'b0, 1'b0);
  wire [22:0] st = step(tot, dn_a, wrap_eff);
  wire signed [20:0] nxt_a = ev_a ? sa[20:0] : pv_a;
  wire signed [20:0] nxt_b = ev_b ? sb[20:0] : pv_b;
  wire signed [21:0] nxt_dual = cfg[`PCO_CF_DSUB] ?
    ({nxt_a[20], nxt_a} - {nxt_b[20], nxt_b}) :
    ({nxt_a[20], nxt_a} + {nxt_b[20], nxt_b});
  wire signed [21:0] dual = cfg[`PCO_CF_DSUB] ?
    ({pv_a[20], pv_a} - {pv_b[20], pv_b}) :
    ({pv_a[20], pv_a} + {pv_b[20], pv_b});
  wire signed [20:0] thr1 = (mode == `PCO_M_FCST) ? (sv2 - sv1) : sv1;
  wire apply = run_sw & ~run_q & (cfg_sw != cfg);
  wire live = (state == ST_RUN);

  // Completion events per configuration
  reg set1;
  reg set2;
  reg done_cycle;
  always @* begin
    set1 = 1'b0;
    set2 = 1'b0;
    done_cycle = 1'b0;
    case (mode)
      `PCO_M_TWO, `PCO_M_FCST: begin
        set1 = ev_a && nxt_a == thr1;
        set2 = ev_a && nxt_a == sv2;
      end
      `PCO_M_BATCH: begin
        done_cycle = ev_a && nxt_a == sv1;
        set2 = done_cycle;
      end
      `PCO_M_DUAL: begin
        set1 = (ev_a | ev_b) && nxt_dual == {sv1[20], sv1};
        set2 = set1;
      end
      `PCO_M_TWIN: begin
        set1 = ev_a && nxt_a == sv1;
        set2 = ev_b && nxt_b == sv2;
      end
      default: begin
        set1 = ev_a && nxt_a == sv1;
        set2 = set1;
      end
    endcase
  end

  // Backup snapshot word
  always @* begin
    case (wr_idx)
      `PCO_BK_PVA: wr_data = {11'h000, pv_a};
      `PCO_BK_PVB: wr_data = {11'h000, pv_b};
      `PCO_BK_BAT: wr_data = {11'h000, bat};
      default: wr_data = {26'h000_0000, ind_force, tot[0], 1'b0, o2, o1};
    endcase
  end

  pco_backup_mem #(
    .DEPTH(4),
    .AW(2),
    .W(32)
  ) u_mem (
    .clock(clock),
    .resetn(resetn),
    .we(live),
    .waddr(wr_idx),
    .wdata(wr_data),
    .raddr(ld_idx[1:0]),
    .rdata(bk_rdata)
  );

  // Core counters, power sequence and configuration apply
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state <= ST_RUN;
      cfg <= `PCO_CTRL_RST;
      run_q <= 1'b0;
      pv_a <= `PCO_PV_ZERO;
      pv_b <= `PCO_PV_ZERO;
      tot <= `PCO_PV_ZERO;
      bat <= `PCO_PV_ZERO;
      o1 <= 1'b0;
      o2 <= 1'b0;
      ind_force <= `PCO_IND_RATIO;
      prev_a <= 1'b0;
      prev_b <= 1'b0;
      ld_idx <= 3'd0;
      wr_idx <= 2'd0;
    end else begin
      run_q <= run_sw;
      prev_a <= count_input_a;
      prev_b <= count_input_b;
      case (state)
        ST_RUN: begin
          wr_idx <= wr_idx + 2'd1;
          if (!power_ok) begin
            state <= ST_OFF;
          end else if (apply) begin
            cfg <= cfg_sw;
            pv_a <= `PCO_PV_ZERO;
            pv_b <= `PCO_PV_ZERO;
            tot <= `PCO_PV_ZERO;
            bat <= `PCO_PV_ZERO;
            o1 <= 1'b0;
            o2 <= 1'b0;
            ind_force <= `PCO_IND_RATIO;
          end else begin
            pv_a <= reset_input_1 ? `PCO_PV_ZERO : nxt_a;
            pv_b <= reset_input_2 ? `PCO_PV_ZERO : nxt_b;
            if (mode == `PCO_M_TOTAL) begin
              if (reset_input_2) begin
                tot <= `PCO_PV_ZERO;
              end else if (ev_a) begin
                tot <= st[20:0];
              end
            end
            // Rollover blanks, wrap lights, next count resumes ratio
            if (ev_a && sa[22]) begin
              ind_force <= `PCO_IND_DARK;
            end else if (ev_a && sa[21]) begin
              ind_force <= `PCO_IND_LIT;
            end else if (ev_a | ev_b) begin
              ind_force <= `PCO_IND_RATIO;
            end
            if (mode == `PCO_M_BATCH) begin
              if (reset_input_2) begin
                bat <= `PCO_PV_ZERO;
                o1 <= 1'b0;
              end else begin
                if (done_cycle) begin
                  bat <= (bat == `PCO_PV_TOP) ? `PCO_PV_ZERO : bat + 21'sd1;
                end
                if (bsv != `PCO_PV_ZERO &&
                    (bat + {20'h0_0000, done_cycle}) >= bsv) begin
                  o1 <= 1'b1;
                end
              end
              o2 <= reset_input_1 ? 1'b0 : (o2 | set2);
            end else if (mode == `PCO_M_TWIN) begin
              o1 <= reset_input_1 ? 1'b0 : (o1 | set1);
              o2 <= reset_input_2 ? 1'b0 : (o2 | set2);
            end else begin
              o1 <= reset_input_1 ? 1'b0 : (o1 | set1);
              o2 <= reset_input_1 ? 1'b0 : (o2 | set2);
            end
          end
        end
        ST_OFF: begin
          ld_idx <= 3'd0;
          if (power_ok) begin
            if (cfg[`PCO_CF_BACKUP]) begin
              state <= ST_LOAD;
            end else begin
              state <= ST_RUN;
              pv_a <= `PCO_PV_ZERO;
              pv_b <= `PCO_PV_ZERO;
              o1 <= 1'b0;
              o2 <= 1'b0;
              ind_force <= `PCO_IND_RATIO;
            end
          end
        end
        ST_LOAD: begin
          // Word of slot ld_idx-1 is on bk_rdata now
          ld_idx <= ld_idx + 3'd1;
          case (ld_idx)
            3'd1: pv_a <= bk_rdata[20:0];
            3'd2: pv_b <= bk_rdata[20:0];
            3'd3: bat <= bk_rdata[20:0];
            3'd4: begin
              o1 <= bk_rdata[0];
              o2 <= bk_rdata[1];
              ind_force <= bk_rdata[5:4];
            end
            default: ld_idx <= 3'd1;
          endcase
          if (ld_idx == `PCO_BK_DONE) begin
            state <= power_ok ? ST_RUN : ST_OFF;
          end
        end
        default: state <= ST_RUN;
      endcase
    end
  end

  // Indicator source and pattern
  reg signed [21:0] ind_pv;
  reg signed [21:0] ind_sv;
  reg [5:0] next_segments;
  always @* begin
    ind_pv = {pv_a[20], pv_a};
    ind_sv = {sv1[20], sv1};
    if (mode == `PCO_M_DUAL) begin
      ind_pv = dual;
    end else if (mode == `PCO_M_TWO || mode == `PCO_M_FCST) begin
      ind_sv = {sv2[20], sv2};
    end
    // Left segment is bit 5; segments clear from the right
    next_segments = ~(6'h3f >> lit_count(ind_pv, ind_sv, dn_a)) & 6'h3f;
    if (ind_pv < 22'sd0) begin
      next_segments = 6'h00;
    end
    if (ind_force == `PCO_IND_DARK) begin
      next_segments = 6'h00;
    end else if (ind_force == `PCO_IND_LIT) begin
      next_segments = 6'h3f;
    end
    case (cfg[`PCO_CF_IND])
      `PCO_IND_DARK: next_segments = 6'h00;
      `PCO_IND_LIT: next_segments = 6'h3f;
      default: next_segments = next_segments;
    endcase
  end

  // Terminal drive, inversion then allocation
  wire t1 = live & (o1 ^ cfg[`PCO_CF_INV1]);
  wire t2 = live & (o2 ^ cfg[`PCO_CF_INV2]);
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      relay_group_out <= 1'b0;
      three_term_group_out <= 1'b0;
      status_segments <= 6'h00;
    end else begin
      relay_group_out <= cfg[`PCO_CF_ALLOC] ? t2 : t1;
      three_term_group_out <= cfg[`PCO_CF_ALLOC] ? t1 : t2;
      status_segments <= live ? next_segments : 6'h00;
    end
  end

  // ON event monitors and run time monitor
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      on_q1 <= 1'b0;
      on_q2 <= 1'b0;
      on_sub1 <= 10'h000;
      on_sub2 <= 10'h000;
      on_mon1 <= 32'h0000_0000;
      on_mon2 <= 32'h0000_0000;
      rt_cnt <= 64'h0000_0000_0000_0000;
      rt_mon <= 32'h0000_0000;
    end else begin
      on_q1 <= o1 & live;
      on_q2 <= o2 & live;
      if (o1 & live & ~on_q1) begin
        on_sub1 <= (on_sub1 == `PCO_ON_LAST) ? 10'h000 : on_sub1 + 10'h001;
        if (on_sub1 == `PCO_ON_LAST) begin
          on_mon1 <= on_mon1 + 32'h0000_0001;
        end
      end
      if (o2 & live & ~on_q2) begin
        on_sub2 <= (on_sub2 == `PCO_ON_LAST) ? 10'h000 : on_sub2 + 10'h001;
        if (on_sub2 == `PCO_ON_LAST) begin
          on_mon2 <= on_mon2 + 32'h0000_0001;
        end
      end
      if (live) begin
        if (rt_cnt >= RT_STEP_CYCLES - 64'h0000_0000_0000_0001) begin
          rt_cnt <= 64'h0000_0000_0000_0000;
          rt_mon <= rt_mon + 32'h0000_0001;
        end else begin
          rt_cnt <= rt_cnt + 64'h0000_0000_0000_0001;
        end
      end
    end
  end

  // Register writes and read data
  wire [31:0] wm_cf = merge({21'h00_0000, cfg_sw}, writedata, byteenable);
  wire [31:0] wm_sv1 = merge({11'h000, sv1}, writedata, byteenable);
  wire [31:0] wm_sv2 = merge({11'h000, sv2}, writedata, byteenable);
  wire [31:0] wm_bsv = merge({11'h000, bsv}, writedata, byteenable);
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ack <= 1'b0;
      readdata <= 32'h0000_0000;
      cfg_sw <= `PCO_CTRL_RST;
      run_sw <= 1'b0;
      sv1 <= `PCO_PV_ZERO;
      sv2 <= `PCO_PV_ZERO;
      bsv <= `PCO_PV_ZERO;
    end else begin
      ack <= (read | write) & ~ack;
      if (wr_go) begin
        case (address)
          `PCO_OFF_CTRL: cfg_sw <= wm_cf[`PCO_CF_W-1:0];
          `PCO_OFF_RUN: run_sw <= byteenable[0] ? writedata[0] : run_sw;
          `PCO_OFF_SV1: sv1 <= wm_sv1[20:0];
          `PCO_OFF_SV2: sv2 <= wm_sv2[20:0];
          `PCO_OFF_BSV: bsv <= wm_bsv[20:0];
          default: run_sw <= run_sw;
        endcase
      end
      if (read & ~ack) begin
        case (address)
          `PCO_OFF_CTRL: readdata <= {21'h00_0000, cfg_sw};
          `PCO_OFF_RUN: readdata <= {31'h0000_0000, run_sw};
          `PCO_OFF_SV1: readdata <= {{11{sv1[20]}}, sv1};
          `PCO_OFF_SV2: readdata <= {{11{sv2[20]}}, sv2};
          `PCO_OFF_BSV: readdata <= {{11{bsv[20]}}, bsv};
          `PCO_OFF_PVA: readdata <= {{11{pv_a[20]}}, pv_a};
          `PCO_OFF_PVB: readdata <= {{11{pv_b[20]}}, pv_b};
          `PCO_OFF_TOT: readdata <= {{11{tot[20]}}, tot};
          `PCO_OFF_BAT: readdata <= {{11{bat[20]}}, bat};
          `PCO_OFF_DUAL: readdata <= {{10{dual[21]}}, dual};
          `PCO_OFF_ON1: readdata <= on_mon1;
          `PCO_OFF_ON2: readdata <= on_mon2;
          `PCO_OFF_RTM: readdata <= rt_mon;
          `PCO_OFF_STAT: readdata <= {16'h0000, state, status_segments,
            4'h0, three_term_group_out, relay_group_out, o2, o1};
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // pco_counter

/* File: hdl/pco_regs.vh */
// Purpose: register map, fields and constants of the preset counter
// Assumes: 32-bit Avalon-MM data, byte addresses on a word grid
// Notes: definitions only
`ifndef PCO_REGS_VH
`define PCO_REGS_VH
// Register byte offsets
`define PCO_OFF_CTRL 6'h00
`define PCO_OFF_RUN 6'h04
`define PCO_OFF_SV1 6'h08
`define PCO_OFF_SV2 6'h0c
`define PCO_OFF_BSV 6'h10
`define PCO_OFF_PVA 6'h14
`define PCO_OFF_PVB 6'h18
`define PCO_OFF_TOT 6'h1c
`define PCO_OFF_BAT 6'h20
`define PCO_OFF_DUAL 6'h24
`define PCO_OFF_ON1 6'h28
`define PCO_OFF_ON2 6'h2c
`define PCO_OFF_RTM 6'h30
`define PCO_OFF_STAT 6'h34
// Configuration fields
`define PCO_CF_W 11
`define PCO_CF_MODE 2:0
`define PCO_CF_ALLOC 3
`define PCO_CF_INV1 4
`define PCO_CF_INV2 5
`define PCO_CF_BACKUP 6
`define PCO_CF_WRAP 7
`define PCO_CF_IND 9:8
`define PCO_CF_DSUB 10
`define PCO_CTRL_RST 11'h000
// Configurations
`define PCO_M_ONE 3'h0
`define PCO_M_TWO 3'h1
`define PCO_M_FCST 3'h2
`define PCO_M_TOTAL 3'h3
`define PCO_M_BATCH 3'h4
`define PCO_M_DUAL 3'h5
`define PCO_M_TWIN 3'h6
// Indicator modes
`define PCO_IND_RATIO 2'h0
`define PCO_IND_DARK 2'h1
`define PCO_IND_LIT 2'h2
// Count range, 21-bit two's complement
`define PCO_PV_TOP 21'h0f_423f
`define PCO_PV_LOW 21'h1e_7961
`define PCO_PV_ZERO 21'h00_0000
// Monitor scaling
`define PCO_ON_LAST 10'h03e7
`define PCO_RT_STEP_S 64'h0000_0000_0030_1ec0
`define PCO_CLK_HZ 64'h0000_0000_05f5_e100
// Backup slots
`define PCO_BK_PVA 2'h0
`define PCO_BK_PVB 2'h1
`define PCO_BK_BAT 2'h2
`define PCO_BK_FLG 2'h3
`define PCO_BK_DONE 3'h4
`endif

/* File: tb/pco_counter_test.sv */
// Purpose: self-checking bench of the preset counter
// Assumes: one wait state per bus access
// Notes: short run-time step keeps the run brief
`timescale 1ns/1ps
module pco_counter_test;
  logic clock, resetn, read, write, count_down, power_ok;
  logic [5:0] address;
  logic [31:0] writedata, q;
  logic [5:0] mon [3] = '{6'h28, 6'h2c, 6'h30};
  wire waitrequest, relay_group_out, three_term_group_out, ca, cb, r1, r2;
  wire [31:0] readdata;
  wire [5:0] status_segments;
  int fails, check_count;
  // Device
  pco_counter #(.RT_STEP_CYCLES(64'h0000_0000_000f_4240)) dut (
    .clock(clock), .resetn(resetn), .address(address), .read(read),
    .write(write), .byteenable(4'hf), .writedata(writedata),
    .waitrequest(waitrequest), .readdata(readdata), .count_input_a(ca),
    .count_input_b(cb), .count_down(count_down), .reset_input_1(r1),
    .reset_input_2(r2), .power_ok(power_ok),
    .relay_group_out(relay_group_out),
    .three_term_group_out(three_term_group_out),
    .status_segments(status_segments));
  // Far side sensors
  pco_sensor u_sen (.clock(clock), .count_input_a(ca), .count_input_b(cb),
    .reset_input_1(r1), .reset_input_2(r2));
  // 100 MHz clock
  always #5 clock = ~clock;
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clock);
    while (waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input string nm, input logic [5:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, q, e);
  endtask
  // Shadow config, then run off and on to apply it
  task automatic cfg(input logic [31:0] c);
    bus(1'b1, 6'h00, c);
    bus(1'b1, 6'h04, 32'h0000_0000);
    bus(1'b1, 6'h04, 32'h0000_0001);
  endtask
  task automatic outs(input logic r, t, input logic [5:0] s);
    repeat (3) @(posedge clock);
    chk("relay", relay_group_out, r);
    chk("three", three_term_group_out, t);
    chk("segs", status_segments, s);
  endtask
  task automatic blackout();
    repeat (8) @(posedge clock);
    power_ok <= 1'b0;
    repeat (5) @(posedge clock);
    power_ok <= 1'b1;
    repeat (15) @(posedge clock);
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock);
    fails++;
    finish_test();
  end
  // Main sequence
  initial begin
    clock = 0; resetn = 0; read = 0; write = 0; count_down = 0;
    power_ok = 1; address = 0; writedata = 0; fails = 0; check_count = 0;
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    rd("ctrl", 6'h00, 32'h0000_0000);
    rd("unmapped", 6'h38, 32'h0000_0000);
    foreach (mon[i]) begin
      bus(1'b1, mon[i], 32'h0000_0005);
      rd("monitor", mon[i], 32'h0000_0000);
    end
    bus(1'b1, 6'h08, 32'h0000_0003);
    u_sen.pulse(2, 0);
    outs(1'b0, 1'b0, 6'h3c);
    u_sen.pulse(1, 0);
    outs(1'b1, 1'b1, 6'h3f);
    rd("pv_a", 6'h14, 32'h0000_0003);
    count_down <= 1'b1;
    u_sen.pulse(1, 0);
    outs(1'b1, 1'b1, 6'h38);
    cfg(32'h0000_0081);
    outs(1'b0, 1'b0, 6'h3f);
    u_sen.pulse(1, 0);
    rd("wrap", 6'h14, 32'h000f_423f);
    outs(1'b0, 1'b0, 6'h3f);
    cfg(32'h0000_0000);
    u_sen.pulse(1, 0);
    rd("below", 6'h14, 32'hffff_ffff);
    outs(1'b0, 1'b0, 6'h00);
    count_down <= 1'b0;
    cfg(32'h0000_0100);
    u_sen.pulse(3, 0);
    outs(1'b1, 1'b1, 6'h00);
    cfg(32'h0000_0200);
    outs(1'b0, 1'b0, 6'h3f);
    cfg(32'h0000_0029);
    bus(1'b1, 6'h08, 32'h0000_0002);
    bus(1'b1, 6'h0c, 32'h0000_0006);
    outs(1'b1, 1'b0, 6'h00);
    u_sen.pulse(2, 0);
    outs(1'b1, 1'b1, 6'h30);
    u_sen.pulse(4, 0);
    outs(1'b0, 1'b1, 6'h3f);
    cfg(32'h0000_0002);
    u_sen.pulse(3, 0);
    outs(1'b0, 1'b0, 6'h38);
    u_sen.pulse(1, 0);
    outs(1'b1, 1'b0, 6'h3c);
    u_sen.pulse(2, 0);
    outs(1'b1, 1'b1, 6'h3f);
    bus(1'b1, 6'h08, 32'h0000_0003);
    cfg(32'h0000_0405);
    u_sen.pulse(5, 2);
    rd("dual_sub", 6'h24, 32'h0000_0003);
    outs(1'b1, 1'b1, 6'h3f);
    cfg(32'h0000_0005);
    u_sen.pulse(2, 1);
    rd("dual_add", 6'h24, 32'h0000_0003);
    outs(1'b1, 1'b1, 6'h3f);
    bus(1'b1, 6'h10, 32'h0000_0001);
    count_down <= 1'b1;
    cfg(32'h0000_0084);
    u_sen.pulse(1, 0);
    rd("nowrap", 6'h14, 32'hffff_ffff);
    count_down <= 1'b0;
    u_sen.pulse(4, 0);
    rd("batch", 6'h20, 32'h0000_0001);
    outs(1'b1, 1'b1, 6'h3f);
    cfg(32'h0000_0006);
    u_sen.pulse(3, 5);
    rd("twin_b", 6'h18, 32'h0000_0005);
    outs(1'b1, 1'b0, 6'h3f);
    bus(1'b1, 6'h08, 32'h0000_0064);
    cfg(32'h0000_0040);
    u_sen.pulse(4, 0);
    blackout();
    rd("kept", 6'h14, 32'h0000_0004);
    cfg(32'h0000_0000);
    u_sen.pulse(4, 0);
    blackout();
    rd("lost", 6'h14, 32'h0000_0000);
    finish_test();
  end
endmodule // pco_counter_test

/* File: tb/pco_sensor.sv */
// Purpose: pulse sensors and reset switches in front of the counter
// Assumes: tasks are entered right after a rising clock edge
// Notes: one count per two clocks, reset switches stay open
`timescale 1ns/1ps
module pco_sensor (
  // Clock
  input wire clock,
  // Sensor lines
  output logic count_input_a,
  output logic count_input_b,
  output logic reset_input_1,
  output logic reset_input_2
);
  // Idle levels
  initial begin
    count_input_a = 1'b0;
    count_input_b = 1'b0;
    reset_input_1 = 1'b0;
    reset_input_2 = 1'b0;
  end
  // Sends na pulses on A and nb on B together
  task automatic pulse(input int na, input int nb);
    int i;
    for (i = 0; i < na || i < nb; i++) begin
      count_input_a <= (i < na);
      count_input_b <= (i < nb);
      @(posedge clock);
      count_input_a <= 1'b0;
      count_input_b <= 1'b0;
      @(posedge clock);
    end
  endtask
endmodule // pco_sensor

/* File: tb/pco_sva.sv */
// Purpose: port checks for the preset counter
// Assumes: one clock domain, reset active low
// Notes: bound to every pco_counter instance
`timescale 1ns/1ps
module pco_sva (
  // Clock and reset
  input wire clock,
  input wire resetn,
  // Register bus
  input wire [5:0] address,
  input wire read,
  input wire write,
  input wire waitrequest,
  input wire [31:0] readdata,
  // Field side
  input wire power_ok,
  input wire relay_group_out,
  input wire three_term_group_out,
  input wire [5:0] status_segments
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Bus handshake, one wait state
  a_wait_first: assert property ((read || write) && !$past(read || write)
    |-> waitrequest) else $error("new request not held off");
  a_wait_one: assert property ((read || write) && !$past(read || write)
    |-> waitrequest ##1 (!waitrequest || !(read || write)))
    else $error("wait state longer than one cycle");
  a_idle_nowait: assert property (!(read || write) |-> !waitrequest)
    else $error("waitrequest without request");
  a_rd_stable: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("read data moved outside a read");
  a_rd_unmapped: assert property (read && !waitrequest && address >= 6'h38
    |-> readdata == 32'h0000_0000) else $error("unmapped read not zero");
  // Segment pattern fills from the left
  a_seg_thermo: assert property (
    status_segments inside {6'h00, 6'h20, 6'h30, 6'h38, 6'h3c, 6'h3e, 6'h3f})
    else $error("segments not filled from the left");
  // Supply loss darkens everything
  a_power_dark: assert property (!power_ok [*3] |->
    status_segments == 6'h00 && !relay_group_out && !three_term_group_out)
    else $error("outputs driven while supply lost");
  a_restore_dark: assert property (!power_ok [*3] ##1 power_ok
    |-> status_segments == 6'h00) else $error("segments lit on return");
endmodule // pco_sva

bind pco_counter pco_sva u_sva (.clock(clock), .resetn(resetn),
  .address(address), .read(read), .write(write),
  .waitrequest(waitrequest), .readdata(readdata), .power_ok(power_ok),
  .relay_group_out(relay_group_out),
  .three_term_group_out(three_term_group_out),
  .status_segments(status_segments));
